// ==== pol_bkt_if.sv ====
// Link between the policer core and one leaky bucket
`timescale 1ns/1ps
`default_nettype none
interface pol_bkt_if;
  logic [31:0] rate;
  logic [31:0] tol;
  logic [31:0] now;
  logic load;
  logic update;
  logic conform;
  logic busy;
  modport core (output rate, tol, now, load, update, input conform, busy);
  modport bucket (input rate, tol, now, load, update, output conform, busy);
endinterface
`default_nettype wire

// ==== pol_bucket.sv ====
// One generic cell rate bucket with its rate to increment divider
`timescale 1ns/1ps
`default_nettype none
module pol_bucket (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  pol_bkt_if.bucket bus
);
  typedef struct packed {
    pol_pkg::pol_bk_state_t state;
    logic [31:0] tat;
    logic [31:0] inc;
    logic [31:0] lim;
    logic [31:0] dvs;
    logic [31:0] dvd;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [4:0] step;
  } pol_bk_st_t;
  pol_bk_st_t st;
  pol_bk_st_t next_st;
  logic [31:0] ahead;
  logic [32:0] rem_sh;

  always_comb begin
    next_st = st;
    ahead = st.tat - bus.now;
    rem_sh = {st.rem, st.dvd[31]};
    bus.busy = st.state != pol_pkg::BK_IDLE;
    // A zero rate never earns credit, so every checked cell fails
    bus.conform = (bus.rate != '0) & ($signed(ahead) <= $signed(st.lim));
    case (st.state)
      pol_pkg::BK_IDLE: begin
        if (bus.load) begin
          next_st.state = pol_pkg::BK_DIV;
          next_st.dvs = bus.rate;
          next_st.dvd = pol_pkg::TICKS_PER_SEC;
          next_st.rem = '0;
          next_st.quo = '0;
          next_st.step = '0;
          next_st.lim = bus.tol;
        end else if (bus.update) begin
          next_st.tat = ($signed(ahead) < 0 ? bus.now : st.tat) + st.inc;
        end
      end
      pol_pkg::BK_DIV: begin
        // Restoring division, one quotient bit per cycle, keeps the block small
        next_st.dvd = st.dvd << 1;
        if (rem_sh >= {1'b0, st.dvs}) begin
          next_st.rem = 32'(rem_sh - {1'b0, st.dvs});
          next_st.quo = {st.quo[30:0], 1'b1};
        end else begin
          next_st.rem = rem_sh[31:0];
          next_st.quo = {st.quo[30:0], 1'b0};
        end
        next_st.step = st.step + 5'h01;
        if (st.step == 5'(pol_pkg::DIV_STEPS - 1)) begin
          next_st.state = pol_pkg::BK_IDLE;
          next_st.inc = next_st.quo;
        end
      end
      default: next_st.state = pol_pkg::BK_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  div_exact_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    st.state == pol_pkg::BK_DIV && st.step == 5'h1f && st.dvs != '0 |=>
    (64'(st.inc) * 64'(st.dvs) <= 64'(pol_pkg::TICKS_PER_SEC)) &&
    ((64'(st.inc) + 64'h1) * 64'(st.dvs) > 64'(pol_pkg::TICKS_PER_SEC)))
    else $error("Bucket increment does not match its rate");

  tat_advance_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    st.state == pol_pkg::BK_IDLE && !bus.load && bus.update |=>
    $signed(st.tat - $past(bus.now) - $past(st.inc)) >= 0)
    else $error("Bucket arrival time did not advance by its increment");
endmodule // pol_bucket
`default_nettype wire

// ==== pol_cell_src.sv ====
// Cell source model standing on the ingress port of the policer
`timescale 1ns/1ps
`default_nettype none
module pol_cell_src (
  input wire logic i_core_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic o_clp,
  output logic [pol_pkg::CELL_W-1:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_clp = 1'b0;
    o_data = '0;
  end

  // Offer one cell and hold it until the policer takes it
  task automatic send(input logic clp, input logic [pol_pkg::CELL_W-1:0] data);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_clp <= clp;
    o_data <= data;
    @(posedge i_core_clk iff i_ready);
    o_valid <= 1'b0;
    // Idle lines carry the inverse so a stale word is never mistaken for a cell
    o_clp <= ~clp;
    o_data <= ~data;
  endtask
endmodule // pol_cell_src
`default_nettype wire

// ==== pol_dual_policer.sv ====
// Dual leaky bucket cell policer for one connection
`timescale 1ns/1ps
`default_nettype none
module pol_dual_policer (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_cell_valid,
  input wire logic i_cell_clp,
  input wire logic [pol_pkg::CELL_W-1:0] i_cell_data,
  output logic o_cell_ready,
  output logic o_cell_valid,
  output logic o_cell_clp,
  output logic [pol_pkg::CELL_W-1:0] o_cell_data,
  input wire logic i_cell_ready,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] pcr_rate;
    logic [31:0] pcr_tol;
    logic [31:0] scr_rate;
    logic [31:0] scr_tol;
    logic [31:0] n_pass;
    logic [31:0] n_tag;
    logic [31:0] n_drop;
    logic [31:0] now;
    logic [31:0] rdata;
    logic [7:0] tick;
    logic [1:0] load;
  } pol_top_st_t;

  localparam pol_top_st_t ST_RST = '{
    ctrl: pol_pkg::RST_CTRL,
    pcr_rate: pol_pkg::RST_PCR_RATE,
    pcr_tol: pol_pkg::RST_PCR_TOL,
    scr_rate: pol_pkg::RST_SCR_RATE,
    scr_tol: pol_pkg::RST_SCR_TOL,
    load: 2'h3,
    default: '0
  };

  pol_top_st_t st;
  pol_top_st_t next_st;
  pol_pkg::pol_mode_t mode;
  logic [2:0] ct;
  logic [2:0] pt;
  logic clp_set;
  logic is_rate;
  logic take;
  logic pcr_chk;
  logic scr_chk;
  logic pcr_fail;
  logic scr_fail;
  logic do_tag;
  logic drop;
  logic push;
  logic clp_out;
  logic fifo_ready;
  logic stall;
  logic [1:0] upd_v;
  logic [1:0] busy_v;
  logic [1:0] conf_v;
  logic [1:0][31:0] rate_v;
  logic [1:0][31:0] tol_v;
  logic [pol_pkg::CELL_W:0] out_word;

  pol_bkt_if bk [2] ();

  function automatic pol_pkg::pol_mode_t mode_of(
    input logic [2:0] c,
    input logic [2:0] p,
    input logic tag_on
  );
    pol_pkg::pol_mode_t m;
    m = '0;
    if (c == pol_pkg::CONN_CBR) begin
      m.pcr_en = p != pol_pkg::PT_OFF;
    end else if (c == pol_pkg::CONN_UBR) begin
      m.pcr_en = 1'b1;
      m.scr_en = tag_on;
      m.scr_clp0 = 1'b1;
      m.scr_tag = 1'b1;
      m.scr_zero = 1'b1;
    end else begin
      // Every other type shares one table, available rate included
      case (p)
        pol_pkg::PT_VBR1: begin
          m.pcr_en = 1'b1;
          m.scr_en = 1'b1;
        end
        pol_pkg::PT_VBR2: begin
          m.pcr_en = 1'b1;
          m.scr_en = 1'b1;
          m.scr_clp0 = 1'b1;
        end
        pol_pkg::PT_PCR_ONLY: m.pcr_en = 1'b1;
        pol_pkg::PT_OFF: m = '0;
        default: begin
          // Unused codes fall back to the usual default, type 3
          m.pcr_en = 1'b1;
          m.scr_en = 1'b1;
          m.scr_clp0 = 1'b1;
          m.scr_tag = 1'b1;
        end
      endcase
    end
    return m;
  endfunction

  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    ct = st.ctrl[pol_pkg::CTRL_TYPE_LSB +: 3];
    pt = st.ctrl[pol_pkg::CTRL_POL_LSB +: 3];
    clp_set = st.ctrl[pol_pkg::CTRL_CLP_BIT];
    is_rate = ct != pol_pkg::CONN_CBR && ct != pol_pkg::CONN_UBR;
    mode = mode_of(ct, pt, clp_set);
    // Cells wait while a bucket relearns its increment, so none is judged on stale rates
    stall = (|st.load) | (|busy_v);
    take = i_cell_valid & fifo_ready & ~stall;
    pcr_chk = take & mode.pcr_en;
    // Low priority cells bypass a high priority only
    scr_chk = take & mode.scr_en & (~mode.scr_clp0 | ~i_cell_clp);
    pcr_fail = pcr_chk & ~conf_v[0];
    scr_fail = scr_chk & ~conf_v[1];
    do_tag = scr_fail & mode.scr_tag & ~i_cell_clp & ~pcr_fail;
    drop = pcr_fail | (scr_fail & ~do_tag);
    push = take & ~drop;
    clp_out = i_cell_clp | do_tag;
    upd_v[0] = pcr_chk & ~drop;
    upd_v[1] = scr_chk & ~scr_fail & ~pcr_fail;

    if (st.tick == '0) begin
      next_st.tick = 8'(pol_pkg::TICK_CYC - 1);
      next_st.now = st.now + 32'h1;
    end else begin
      next_st.tick = st.tick - 8'h01;
    end

    // A reload stays pending until the bucket is idle and takes it
    next_st.load = st.load & busy_v;
    if (i_reg_wr) begin
      case (i_reg_addr)
        pol_pkg::OFF_CTRL: begin
          next_st.ctrl = i_reg_wdata & pol_pkg::CTRL_MASK;
          next_st.load = 2'h3;
        end
        pol_pkg::OFF_PCR_RATE: begin
          next_st.pcr_rate = i_reg_wdata;
          next_st.load[0] = 1'b1;
        end
        pol_pkg::OFF_PCR_TOL: begin
          next_st.pcr_tol = i_reg_wdata;
          next_st.load[0] = 1'b1;
        end
        pol_pkg::OFF_SCR_RATE: begin
          next_st.scr_rate = i_reg_wdata;
          next_st.load[1] = 1'b1;
        end
        pol_pkg::OFF_SCR_TOL: begin
          next_st.scr_tol = i_reg_wdata;
          next_st.load[1] = 1'b1;
        end
        pol_pkg::OFF_PASS: next_st.n_pass = '0;
        pol_pkg::OFF_TAG: next_st.n_tag = '0;
        pol_pkg::OFF_DROP: next_st.n_drop = '0;
        default: next_st.load = next_st.load;
      endcase
    end

    // Counting after the clear keeps a cell that lands on a clear
    next_st.n_pass = next_st.n_pass + 32'(push & ~do_tag);
    next_st.n_tag = next_st.n_tag + 32'(do_tag);
    next_st.n_drop = next_st.n_drop + 32'(take & drop);

    if (i_reg_rd) begin
      case (i_reg_addr)
        pol_pkg::OFF_CTRL: next_st.rdata = st.ctrl;
        pol_pkg::OFF_PCR_RATE: next_st.rdata = st.pcr_rate;
        pol_pkg::OFF_PCR_TOL: next_st.rdata = st.pcr_tol;
        pol_pkg::OFF_SCR_RATE: next_st.rdata = st.scr_rate;
        pol_pkg::OFF_SCR_TOL: next_st.rdata = st.scr_tol;
        pol_pkg::OFF_STATUS: next_st.rdata = {21'h0, ~fifo_ready, st.load, busy_v, 1'b0, mode};
        pol_pkg::OFF_PASS: next_st.rdata = st.n_pass;
        pol_pkg::OFF_TAG: next_st.rdata = st.n_tag;
        pol_pkg::OFF_DROP: next_st.rdata = st.n_drop;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rate_v[0] = st.pcr_rate;
  assign tol_v[0] = st.pcr_tol;
  assign rate_v[1] = mode.scr_zero ? 32'h0 : st.scr_rate;
  assign tol_v[1] = st.scr_tol;

  for (genvar g = 0; g < 2; g++) begin : g_bkt
    assign bk[g].rate = rate_v[g];
    assign bk[g].tol = tol_v[g];
    assign bk[g].now = st.now;
    assign bk[g].load = st.load[g];
    assign bk[g].update = upd_v[g];
    assign conf_v[g] = bk[g].conform;
    assign busy_v[g] = bk[g].busy;
    pol_bucket u_bkt (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .bus(bk[g])
    );
  end

  pol_fifo #(
    .W(pol_pkg::CELL_W + 1),
    .DEPTH(pol_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(push),
    .o_ready(fifo_ready),
    .i_data({clp_out, i_cell_data}),
    .o_valid(o_cell_valid),
    .i_ready(i_cell_ready),
    .o_data(out_word)
  );

  assign o_cell_ready = fifo_ready & ~stall;
  assign o_cell_clp = out_word[pol_pkg::CELL_W];
  assign o_cell_data = out_word[pol_pkg::CELL_W-1:0];
  assign o_reg_rdata = st.rdata;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  cbr_pcr_only_a: assert property (
    take && ct == pol_pkg::CONN_CBR && pt != pol_pkg::PT_OFF |-> pcr_chk && !scr_chk && !do_tag)
    else $error("Constant rate cell not judged by first bucket alone");

  off_pass_a: assert property (
    take && ct != pol_pkg::CONN_UBR && pt == pol_pkg::PT_OFF && !i_reg_wr
    |-> push && clp_out == i_cell_clp ##1 st.n_pass == $past(st.n_pass) + 32'h1)
    else $error("Unpoliced cell was not passed untouched");

  ubr_plain_a: assert property (
    take && ct == pol_pkg::CONN_UBR && !clp_set |-> pcr_chk && !scr_chk && !do_tag)
    else $error("Untagged unspecified rate cell judged wrongly");

  ubr_tag_a: assert property (
    take && ct == pol_pkg::CONN_UBR && clp_set && !i_cell_clp && !pcr_fail
    |-> do_tag && push)
    else $error("High priority unspecified rate cell not tagged");

  ubr_zero_rate_a: assert property (
    ct == pol_pkg::CONN_UBR && clp_set && !stall |-> !conf_v[1])
    else $error("Second bucket conforms at a zero rate");

  vbr1_both_a: assert property (
    take && is_rate && pt == pol_pkg::PT_VBR1 |-> pcr_chk && scr_chk && !do_tag)
    else $error("Type 1 cell not judged by both buckets");

  vbr2_clp0_a: assert property (
    take && is_rate && pt == pol_pkg::PT_VBR2 |-> scr_chk == !i_cell_clp && !do_tag)
    else $error("Type 2 second bucket scope wrong");

  vbr3_tag_a: assert property (
    take && is_rate && pt == pol_pkg::PT_VBR3 && scr_fail && !pcr_fail && !i_reg_wr
    |-> push ##1 st.n_tag == $past(st.n_tag) + 32'h1)
    else $error("Type 3 failing cell was not tagged");

  pcr_only_a: assert property (
    take && is_rate && pt == pol_pkg::PT_PCR_ONLY |-> pcr_chk && !scr_chk && !do_tag)
    else $error("Type 4 cell reached the second bucket");

  tag_sets_clp_a: assert property (
    do_tag |-> push && clp_out && !i_cell_clp)
    else $error("Tagged cell did not get its priority bit set");

  abr_as_vbr_a: assert property (
    ct == pol_pkg::CONN_ABR |-> !mode.scr_zero && mode.pcr_en == (pt != pol_pkg::PT_OFF) &&
    mode.scr_en == (mode.pcr_en && pt != pol_pkg::PT_PCR_ONLY) &&
    mode.scr_clp0 == (mode.scr_en && pt != pol_pkg::PT_VBR1) &&
    mode.scr_tag == (mode.scr_clp0 && pt != pol_pkg::PT_VBR2))
    else $error("Available rate mode differs from variable rate");

  clp1_untagged_a: assert property (
    take && i_cell_clp |-> !do_tag && (!scr_chk || !mode.scr_clp0))
    else $error("Low priority cell handled as high priority");

  fail_drop_a: assert property (
    pcr_fail && !i_reg_wr |-> !push && !upd_v[0] && !upd_v[1]
    ##1 st.n_drop == $past(st.n_drop) + 32'h1)
    else $error("Failing cell was kept or updated its bucket");

  off_no_update_a: assert property (
    pt == pol_pkg::PT_OFF && ct != pol_pkg::CONN_UBR |-> !upd_v[0] && !upd_v[1] && !do_tag)
    else $error("Unpoliced connection touched a bucket");

  cbr_scr_off_a: assert property (
    ct == pol_pkg::CONN_CBR |-> !scr_chk && !upd_v[1])
    else $error("Constant rate cell reached the second bucket");

  scr_zero_rate_a: assert property (
    mode.scr_zero |-> rate_v[1] == 32'h0)
    else $error("Second bucket rate is not zero in tagging mode");

  stale_rate_a: assert property (
    stall |-> !o_cell_ready && !upd_v[0] && !upd_v[1])
    else $error("Cell judged while a bucket relearns its rate");

  tag_count_a: assert property (
    do_tag && !i_reg_wr |=> st.n_tag == $past(st.n_tag) + 32'h1)
    else $error("Tagged cell was not counted");

  clp1_kept_a: assert property (
    push && i_cell_clp |-> clp_out)
    else $error("Low priority cell was raised in priority");

  scr_fail_hold_a: assert property (
    scr_fail |-> !upd_v[1] && (do_tag || !push))
    else $error("Second bucket failure kept an untagged cell");
endmodule // pol_dual_policer
`default_nettype wire

// ==== pol_fifo.sv ====
// Cell FIFO between the policer and the queues
`timescale 1ns/1ps
`default_nettype none
module pol_fifo #(
  parameter int W = 33,
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pol_fifo_st_t;
  pol_fifo_st_t st;
  pol_fifo_st_t next_st;
  logic wr;
  logic rd;

  always_comb begin
    next_st = st;
    o_ready = st.cnt != (AW+1)'(DEPTH);
    o_valid = st.cnt != '0;
    o_data = st.mem[st.rp];
    wr = i_valid & o_ready;
    rd = o_valid & i_ready;
    if (wr) begin
      next_st.mem[st.wp] = i_data;
      next_st.wp = st.wp + 1'b1;
    end
    if (rd) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // pol_fifo
`default_nettype wire

// ==== pol_pkg.sv ====
// Constants and types of the dual bucket cell policer
package pol_pkg;
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] TICKS_PER_SEC = 32'h000f4240;
  localparam int CELL_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int DIV_STEPS = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PCR_RATE = 8'h04;
  localparam logic [7:0] OFF_PCR_TOL = 8'h08;
  localparam logic [7:0] OFF_SCR_RATE = 8'h0c;
  localparam logic [7:0] OFF_SCR_TOL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PASS = 8'h18;
  localparam logic [7:0] OFF_TAG = 8'h1c;
  localparam logic [7:0] OFF_DROP = 8'h20;
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_POL_LSB = 4;
  localparam int CTRL_CLP_BIT = 8;
  localparam logic [31:0] CTRL_MASK = 32'h00000177;
  localparam logic [31:0] RST_CTRL = 32'h00000133;
  localparam logic [31:0] RST_PCR_RATE = 32'h00000032;
  localparam logic [31:0] RST_PCR_TOL = 32'h0003d090;
  localparam logic [31:0] RST_SCR_RATE = 32'h00000032;
  localparam logic [31:0] RST_SCR_TOL = 32'h000003e8;
  typedef enum logic [2:0] {
    CONN_CBR = 3'h0, CONN_UBR = 3'h1, CONN_VBR_RT = 3'h2, CONN_VBR_NRT = 3'h3,
    CONN_ABR = 3'h4, CONN_FRAME = 3'h5, CONN_FRAME_ST = 3'h6
  } pol_conn_t;
  typedef enum logic [2:0] {
    PT_VBR1 = 3'h1, PT_VBR2 = 3'h2, PT_VBR3 = 3'h3, PT_PCR_ONLY = 3'h4, PT_OFF = 3'h5
  } pol_ptype_t;
  typedef struct packed {
    logic pcr_en;
    logic scr_en;
    logic scr_clp0;
    logic scr_tag;
    logic scr_zero;
  } pol_mode_t;
  typedef enum logic [1:0] {BK_IDLE = 2'b00, BK_DIV = 2'b01} pol_bk_state_t;
endpackage

// ==== test_pol_dual_policer.sv ====
// Self-checking bench of the dual bucket cell policer
`timescale 1ns/1ps
`default_nettype none
module test_pol_dual_policer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv;
  logic cclp;
  logic [pol_pkg::CELL_W-1:0] cdata;
  logic crdy;
  logic ov;
  logic oclp;
  logic [pol_pkg::CELL_W-1:0] odata;
  logic sready = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [32:0] got[$];
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  pol_dual_policer uut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_cell_valid(cv), .i_cell_clp(cclp),
    .i_cell_data(cdata), .o_cell_ready(crdy), .o_cell_valid(ov), .o_cell_clp(oclp),
    .o_cell_data(odata), .i_cell_ready(sready), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata)
  );
  pol_cell_src src (
    .i_core_clk(clk), .i_ready(crdy), .o_valid(cv), .o_clp(cclp), .o_data(cdata)
  );

  always #2.5 clk = ~clk;

  // Collects every cell the sink takes; also cuts a hung run short
  always @(posedge clk) begin
    if (ov === 1'b1 && sready === 1'b1) begin
      got.push_back({oclp, odata});
    end
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[FAIL] run length expected below %0d cycles seen %0d", 20000, cycles);
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Full reset per scenario so no bucket carries state from the last one
  task automatic restart(input logic [31:0] ctrl, input logic [31:0] srate,
                         input logic [31:0] stol);
    int n;
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr_reg(pol_pkg::OFF_SCR_RATE, srate);
    wr_reg(pol_pkg::OFF_SCR_TOL, stol);
    wr_reg(pol_pkg::OFF_CTRL, ctrl);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (crdy !== 1'b1 && n < 100);
    chk("reload done", 33'h1, {32'h0, crdy});
    got.delete();
  endtask

  task automatic send_seq(input logic [31:0] clp_in, input int n);
    for (int i = 0; i < n; i++) begin
      src.send(clp_in[i], 32'hc0000000 + i);
    end
  endtask

  // Kept cells must leave in order with the expected priority bit
  task automatic chk_out(input logic [31:0] keep, input logic [31:0] clp_out, input int n);
    logic [32:0] c;
    repeat (24) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (keep[i]) begin
        c = (got.size() > 0) ? got.pop_front() : 33'bx;
        chk("cell", {clp_out[i], 32'hc0000000 + i}, c);
      end
    end
    chk("cells left", 33'h0, 33'(got.size()));
  endtask

  task automatic chk_cnt(input logic [31:0] p, input logic [31:0] t, input logic [31:0] d);
    logic [31:0] v;
    rd_reg(pol_pkg::OFF_PASS, v);
    chk("pass count", {1'b0, p}, {1'b0, v});
    rd_reg(pol_pkg::OFF_TAG, v);
    chk("tag count", {1'b0, t}, {1'b0, v});
    rd_reg(pol_pkg::OFF_DROP, v);
    chk("drop count", {1'b0, d}, {1'b0, v});
  endtask

  task automatic t_regs();
    logic [31:0] v;
    rd_reg(pol_pkg::OFF_CTRL, v);
    chk("ctrl reset", {1'b0, pol_pkg::RST_CTRL}, {1'b0, v});
    // Read data must fall back to zero once its cycle is over
    @(posedge clk);
    #1;
    chk("rdata idle", 33'h0, {1'b0, rdata});
    rd_reg(pol_pkg::OFF_PCR_TOL, v);
    chk("pcr tol reset", {1'b0, pol_pkg::RST_PCR_TOL}, {1'b0, v});
    rd_reg(8'h40, v);
    chk("unmapped read", 33'h0, {1'b0, v});
    wr_reg(pol_pkg::OFF_CTRL, 32'hffffffff);
    rd_reg(pol_pkg::OFF_CTRL, v);
    chk("ctrl reserved", {1'b0, pol_pkg::CTRL_MASK}, {1'b0, v});
    $display("test regs done");
  endtask

  // Entry: expected mode in [16:12], control word in [11:0]
  task automatic t_modes();
    logic [19:0] tbl [14] = '{20'h10040, 20'h00050, 20'h10031, 20'h1f131, 20'h18013,
      20'h1c023, 20'h1e033, 20'h10043, 20'h00053, 20'h18114, 20'h1c024, 20'h1e034,
      20'h1e035, 20'h10042};
    logic [31:0] v;
    logic [4:0] m;
    logic [4:0] e;
    for (int i = 0; i < 14; i++) begin
      wr_reg(pol_pkg::OFF_CTRL, {20'h0, tbl[i][11:0]});
      rd_reg(pol_pkg::OFF_STATUS, v);
      // Qualifier bits of a disabled second bucket carry no meaning
      m = tbl[i][15] ? 5'h1f : 5'h18;
      e = tbl[i][16:12] & m;
      chk("mode", {28'h0, e}, {28'h0, v[4:0] & m});
    end
    $display("test modes done");
  endtask

  task automatic t_off_fifo();
    logic [31:0] v;
    restart(32'h00000053, 32'h1, 32'h0);
    @(posedge clk);
    sready <= 1'b0;
    send_seq(32'haaaa, 16);
    rd_reg(pol_pkg::OFF_STATUS, v);
    chk("fifo full", 33'h1, {32'h0, v[10]});
    chk("ready when full", 33'h0, {32'h0, crdy});
    @(posedge clk);
    sready <= 1'b1;
    src.send(1'b0, 32'hc0000010);
    chk_out(32'h1ffff, 32'haaaa, 17);
    chk_cnt(17, 0, 0);
    $display("test off and fifo done");
  endtask

  task automatic t_pcr_only();
    int ok;
    logic [31:0] v;
    ok = int'(pol_pkg::RST_PCR_TOL / (pol_pkg::TICKS_PER_SEC / pol_pkg::RST_PCR_RATE)) + 1;
    restart(32'h00000040, 32'h1, 32'h0);
    send_seq(32'h0, ok + 2);
    chk_out((32'h1 << ok) - 1, 32'h0, ok + 2);
    chk_cnt(ok, 0, 2);
    wr_reg(pol_pkg::OFF_DROP, 32'h0);
    rd_reg(pol_pkg::OFF_DROP, v);
    chk("drop clear", 33'h0, {1'b0, v});
    $display("test peak only done");
  endtask

  task automatic t_ubr_plain();
    restart(32'h00000031, pol_pkg::RST_SCR_RATE, pol_pkg::RST_SCR_TOL);
    send_seq(32'h0, 3);
    chk_out(32'h7, 32'h0, 3);
    chk_cnt(3, 0, 0);
    $display("test ubr plain done");
  endtask

  task automatic t_ubr_tag();
    restart(32'h00000131, pol_pkg::RST_SCR_RATE, pol_pkg::RST_SCR_TOL);
    send_seq(32'h2, 4);
    chk_out(32'hf, 32'hf, 4);
    chk_cnt(1, 3, 0);
    $display("test ubr tagging done");
  endtask

  task automatic t_vbr3();
    restart(32'h00000033, 32'h1, 32'h0);
    send_seq(32'h4, 4);
    chk_out(32'hf, 32'he, 4);
    chk_cnt(2, 2, 0);
    $display("test type 3 done");
  endtask

  task automatic t_vbr2();
    restart(32'h00000023, 32'h1, 32'h0);
    send_seq(32'h4, 4);
    chk_out(32'h5, 32'h4, 4);
    chk_cnt(2, 0, 2);
    $display("test type 2 done");
  endtask

  // A live second bucket would drop the second high priority cell
  task automatic t_rt_pcr();
    restart(32'h00000042, 32'h1, 32'h0);
    send_seq(32'h0, 2);
    chk_out(32'h3, 32'h0, 2);
    chk_cnt(2, 0, 0);
    $display("test type 4 rate done");
  endtask

  task automatic t_abr1();
    restart(32'h00000014, 32'h1, 32'h0);
    send_seq(32'h2, 2);
    chk_out(32'h1, 32'h0, 2);
    chk_cnt(1, 0, 1);
    $display("test type 1 done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_off_fifo();
    t_pcr_only();
    t_ubr_plain();
    t_ubr_tag();
    t_vbr3();
    t_vbr2();
    t_abr1();
    t_rt_pcr();
    close_out();
  end
endmodule // test_pol_dual_policer
`default_nettype wire
